/* File: sar_adc_dev.sv */
// Purpose: converter end, successive approximation stepped by the shift clock
// Assumes: shift clock held low at select fall; no clock of its own
// Notes:   select high, power-down or reset hold the shift logic idle
`timescale 1ns/1ps
module sar_adc_dev
   import sar_pkg::*;
#(
   parameter int BITS = RESULT_BITS
) (
   // reset
   input  wire logic                   resetn,
   // link
   sar_link_if.device                  link,
   // analog stand-in and status
   input  wire logic [BITS-1:0]        analogLevel,
   output logic                        refEnable,
   output logic                        trackMode,
   output logic [BITS-1:0]             lastResult
);

   logic [BITS-1:0]          held;
   logic [BITS-1:0]          approx;
   logic [BITS-1:0]          mask;
   logic [EDGE_CNT_BITS-1:0] edges;
   logic                     dataBit;
   logic                     converting;

   // shift logic is held idle outside an active frame
   wire idle    = link.convSelectN | ~link.powerDownN | ~resetn;
   wire inData  = (edges >= EDGE_CNT_BITS'(LEAD_EDGES)) && (mask != '0);
   wire [BITS-1:0] trial  = approx | mask;
   wire            keep   = (held >= trial);
   wire            active = ~link.convSelectN & link.powerDownN & resetn;

   // select fall freezes the sample
   always_ff @(negedge link.convSelectN or negedge resetn) begin
      if (!resetn) begin
         held <= RESULT_RESET;
      end else begin
         held <= analogLevel;
      end
   end

   // output driven low from select fall, released on select rise
   assign link.serialOutEn = active;
   assign link.serialOut   = dataBit;

   always_ff @(posedge link.shiftClock or posedge idle) begin
      if (idle) begin
         edges      <= '0;
         approx     <= RESULT_RESET;
         mask       <= MASK_START;
         dataBit    <= 1'b0;
         converting <= 1'b1;
      end else begin
         if (edges != EDGE_CNT_BITS'(FRAME_EDGES)) begin
            edges <= edges + EDGE_CNT_BITS'(1);
         end
         if (inData) begin
            dataBit <= keep;
            approx  <= keep ? trial : approx;
            mask    <= mask >> 1;
            if (mask == BITS'(1)) begin
               converting <= 1'b0;
            end
         end else begin
            dataBit <= 1'b0;
         end
      end
   end

   // finished result, kept after the frame
   always_ff @(posedge link.shiftClock or negedge resetn) begin
      if (!resetn) begin
         lastResult <= RESULT_RESET;
      end else if (!idle && inData && mask == BITS'(1)) begin
         lastResult <= keep ? trial : approx;
      end
   end

   assign refEnable = link.powerDownN;
   assign trackMode = ~active | ~converting;

endmodule : sar_adc_dev

/* File: sar_host.sv */
// Purpose: controller end, makes select and shift clock, collects results
// Assumes: mclk 10 MHz, link clock derived here by a divider
// Notes:   serial line passes two flip-flops before use
`timescale 1ns/1ps
module sar_host
   import sar_pkg::*;
#(
   parameter int HALF_CYC   = 3,
   parameter int COLD_CYC   = COLD_START_CYC,
   parameter int WAKE_CYC   = WAKE_DELAY_CYC
) (
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   resetn,
   // link
   sar_link_if.host                    link,
   // user side
   input  wire logic                   startReq,
   input  wire logic                   sleepReq,
   output logic                        ready,
   output logic                        resultValid,
   output logic [RESULT_BITS-1:0]      result
);

   typedef enum logic [2:0] {H_WARM, H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_SLEEP} sar_hstate_t;

   sar_hstate_t          state;
   logic [31:0]          cnt;
   logic [EDGE_CNT_BITS-1:0] edges;
   logic                 syncA;
   logic                 syncB;
   logic                 selN;
   logic                 sclk;
   logic                 pdn;
   logic [RESULT_BITS-1:0] shiftIn;

   wire cntDone  = (cnt == 32'h0);
   wire lastEdge = (edges == EDGE_CNT_BITS'(FRAME_EDGES));
   wire takeBit  = (edges > EDGE_CNT_BITS'(LEAD_EDGES)) && !lastEdge;
   localparam int GAP_CYC = (SEL_HIGH_CYC > ACQUIRE_CYC) ? SEL_HIGH_CYC : ACQUIRE_CYC;

   assign link.convSelectN = selN;
   assign link.shiftClock  = sclk;
   assign link.powerDownN  = pdn;

   // serial line synchroniser
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         syncA <= 1'b0;
         syncB <= 1'b0;
      end else begin
         syncA <= link.serialLine;
         syncB <= syncA;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state       <= H_WARM;
         cnt         <= 32'(COLD_CYC);
         edges       <= '0;
         selN        <= 1'b1;
         sclk        <= 1'b0;
         pdn         <= 1'b1;
         ready       <= 1'b0;
         resultValid <= 1'b0;
         result      <= RESULT_RESET;
         shiftIn     <= RESULT_RESET;
      end else begin
         resultValid <= 1'b0;
         case (state)
            H_WARM: begin
               pdn <= 1'b1;
               if (cntDone) begin
                  state <= H_IDLE;
                  ready <= 1'b1;
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            H_IDLE: begin
               if (sleepReq) begin
                  state <= H_SLEEP;
                  pdn   <= 1'b0;
                  ready <= 1'b0;
               end else if (startReq) begin
                  selN  <= 1'b0;
                  sclk  <= 1'b0;
                  edges <= '0;
                  ready <= 1'b0;
                  cnt   <= 32'(SEL_SETUP_CYC);
                  state <= H_SETUP;
               end
            end
            H_SETUP: begin
               if (cntDone) begin
                  state <= H_LOW;
                  cnt   <= 32'(HALF_CYC - 1);
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            H_LOW: begin
               if (!cntDone) begin
                  cnt <= cnt - 32'h1;
               end else if (lastEdge) begin
                  selN        <= 1'b1;
                  result      <= shiftIn;
                  resultValid <= 1'b1;
                  cnt         <= 32'(GAP_CYC);
                  state       <= H_GAP;
               end else begin
                  if (takeBit) begin
                     shiftIn <= {shiftIn[RESULT_BITS-2:0], syncB};
                  end
                  sclk  <= 1'b1;
                  edges <= edges + EDGE_CNT_BITS'(1);
                  cnt   <= 32'(HALF_CYC - 1);
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (cntDone) begin
                  sclk  <= 1'b0;
                  cnt   <= 32'(HALF_CYC - 1);
                  state <= H_LOW;
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            H_GAP: begin
               if (cntDone) begin
                  state <= H_IDLE;
                  ready <= 1'b1;
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            H_SLEEP: begin
               if (!sleepReq) begin
                  pdn   <= 1'b1;
                  cnt   <= 32'(WAKE_CYC);
                  state <= H_WARM;
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

endmodule : sar_host

/* File: sar_link_checker.sv */
// Purpose: link protocol assertions
// Assumes: link signals sampled on mclk
// Notes:   edgeCnt counts shift clock rises per frame
`timescale 1ns/1ps
module sar_link_checker (
   // clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // link
   input  wire logic convSelectN,
   input  wire logic shiftClock,
   input  wire logic powerDownN,
   input  wire logic serialOut,
   input  wire logic serialOutEn,
   input  wire logic serialLine
);
   logic       prevSclk;
   logic [4:0] edgeCnt;
   wire        sclkRise     = shiftClock & ~prevSclk;
   wire        cntMax       = (edgeCnt == 5'h1F);
   wire  [4:0] next_edgeCnt = convSelectN ? 5'h00 : edgeCnt + {4'h0, sclkRise & ~cntMax};
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prevSclk <= 1'b0;
         edgeCnt  <= 5'h00;
      end else begin
         prevSclk <= shiftClock;
         edgeCnt  <= next_edgeCnt;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_frameStart; $fell(convSelectN) ##0 powerDownN; endsequence
   sequence s_drivenLow; serialOutEn && !serialLine; endsequence
   a_start_drives_low: assert property (s_frameStart |-> s_drivenLow)
      else $error("line not low at frame start");
   a_idle_line_off: assert property (convSelectN |-> !serialOutEn)
      else $error("line driven while idle");
   a_sleep_line_off: assert property (!powerDownN |-> !serialOutEn)
      else $error("line driven in shutdown");
   a_idle_bit_low: assert property (convSelectN |-> !serialOut)
      else $error("data bit not cleared while idle");
   a_lead_zeros: assert property ((!convSelectN && edgeCnt <= 5'h02 && !sclkRise) |-> !serialLine)
      else $error("leading bit not zero");
   a_trail_zeros: assert property ((!convSelectN && edgeCnt >= 5'h0F) |-> !serialLine)
      else $error("trailing bit not zero");
   a_rise_only: assert property ((!convSelectN && $past(!convSelectN) && $changed(serialLine)) |-> sclkRise)
      else $error("line moved off a rising edge");
   a_sclk_low_start: assert property ($fell(convSelectN) |-> !shiftClock)
      else $error("shift clock high at select fall");
   a_full_frame: assert property ($rose(convSelectN) |-> edgeCnt >= 5'h0F)
      else $error("frame ended early");
   a_sclk_width: assert property ($rose(shiftClock) |-> shiftClock[*2])
      else $error("shift clock high phase short");
   a_select_gap: assert property ($rose(convSelectN) |-> convSelectN[*7])
      else $error("select high gap short");
   a_wake_wait: assert property ($rose(powerDownN) |-> convSelectN[*8])
      else $error("start too soon after wake");
endmodule : sar_link_checker

/* File: sar_link_if.sv */
// Purpose: three-wire link plus power-down pin between host and converter
// Assumes: serial line reads low when nobody drives it
// Notes:   serialLine is the resolved wire level
`timescale 1ns/1ps
interface sar_link_if;
   logic convSelectN;
   logic shiftClock;
   logic powerDownN;
   logic serialOut;
   logic serialOutEn;
   logic serialLine;

   assign serialLine = serialOutEn & serialOut;

   modport device (
      input  convSelectN,
      input  shiftClock,
      input  powerDownN,
      output serialOut,
      output serialOutEn
   );

   modport host (
      output convSelectN,
      output shiftClock,
      output powerDownN,
      input  serialLine
   );
endinterface : sar_link_if

/* File: sar_pkg.sv */
// Purpose: shared constants for the serial converter link
// Assumes: host runs on mclk at 10 MHz
// Notes:   times are kept in ns, counts derived from them
package sar_pkg;

   // converter geometry
   localparam int RESULT_BITS      = 12;
   localparam int LEAD_EDGES       = 2;
   localparam int FRAME_EDGES      = 15;
   localparam int EDGE_CNT_BITS    = 4;

   // clock and link timing
   localparam int MCLK_PERIOD_NS   = 100;
   localparam int SCLK_MIN_PER_NS  = 208;
   localparam int SEL_SETUP_NS     = 45;
   localparam int SEL_HIGH_NS      = 100;
   localparam int ACQUIRE_NS       = 625;
   localparam int COLD_START_NS    = 2500000;
   localparam int WAKE_DELAY_NS    = 100000;

   // derived cycle counts, least times rounded up
   localparam int SCLK_HALF_CYC    = (SCLK_MIN_PER_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SEL_SETUP_CYC    = (SEL_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SEL_HIGH_CYC     = (SEL_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int ACQUIRE_CYC      = (ACQUIRE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int COLD_START_CYC   = (COLD_START_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int WAKE_DELAY_CYC   = (WAKE_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // reset values
   localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;
   localparam logic [RESULT_BITS-1:0] MASK_START   = 12'h800;

endpackage : sar_pkg

/* File: tb_top.sv */
// Purpose: end-to-end bench for host and converter
// Assumes: mclk 10 MHz, shift clock made by the host
// Notes:   short cold start and wake counts
`timescale 1ns/1ps
module tb_top;
   import sar_pkg::*;
   localparam int COLD_TB = 20;
   localparam int WAKE_TB = 10;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        startReq = 1'b0;
   logic        sleepReq = 1'b0;
   logic [11:0] analogLevel = 12'h000;
   logic        ready, resultValid, refEnable, trackMode;
   logic [11:0] result, lastResult;
   logic [14:0] frame;
   int          errors = 0;
   int          totalChecks = 0;
   always #50 mclk = ~mclk;
   sar_link_if link ();
   sar_host #(.COLD_CYC(COLD_TB), .WAKE_CYC(WAKE_TB)) u_sar_host (.mclk(mclk), .resetn(resetn),
      .link(link), .startReq(startReq), .sleepReq(sleepReq), .ready(ready),
      .resultValid(resultValid), .result(result));
   sar_adc_dev u_sar_adc_dev (.resetn(resetn), .link(link), .analogLevel(analogLevel),
      .refEnable(refEnable), .trackMode(trackMode), .lastResult(lastResult));
   sar_link_checker u_sar_link_checker (.mclk(mclk), .resetn(resetn),
      .convSelectN(link.convSelectN), .shiftClock(link.shiftClock),
      .powerDownN(link.powerDownN), .serialOut(link.serialOut),
      .serialOutEn(link.serialOutEn), .serialLine(link.serialLine));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      if (errors == 0 && totalChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   task automatic await_ready(input int limit);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < limit) begin
         @(negedge mclk);
         n++;
      end
      check(16'(ready), 16'h0001);
   endtask : await_ready
   task automatic do_conv(input logic [11:0] level);
      int n;
      @(posedge mclk);
      analogLevel <= level;
      startReq    <= 1'b1;
      @(negedge link.convSelectN);
      @(posedge mclk);
      analogLevel <= ~level;
      startReq    <= 1'b0;
      for (n = 0; n < 15; n++) begin
         @(posedge link.shiftClock);
         #50 frame = {frame[13:0], link.serialLine};
         if (n == 2) check(16'(trackMode), 16'h0000);
         if (n == 14) check(16'(trackMode), 16'h0001);
      end
      check(16'(frame), 16'({2'b00, level, 1'b0}));
      n = 0;
      while (resultValid !== 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      check(16'(result), 16'(level));
      check(16'(lastResult), 16'(level));
      @(negedge mclk);
      check(16'(trackMode), 16'h0001);
   endtask : do_conv
   task automatic test_cold;
      repeat (COLD_TB) @(negedge mclk);
      check(16'(ready), 16'h0000);
      check(16'(link.serialOutEn), 16'h0000);
      repeat (2) @(negedge mclk);
      check(16'(ready), 16'h0001);
   endtask : test_cold
   task automatic test_codes;
      logic [11:0] codes [4] = '{12'hFFF, 12'h000, 12'hA5C, 12'h801};
      foreach (codes[i]) do_conv(codes[i]);
   endtask : test_codes
   task automatic test_sleep;
      await_ready(20);
      @(posedge mclk);
      sleepReq <= 1'b1;
      repeat (3) @(negedge mclk);
      check(16'(refEnable), 16'h0000);
      check(16'(link.serialOutEn), 16'h0000);
      @(posedge mclk);
      sleepReq <= 1'b0;
      repeat (3) @(negedge mclk);
      check(16'(refEnable), 16'h0001);
      check(16'(ready), 16'h0000);
      await_ready(40);
      do_conv(12'h3C7);
   endtask : test_sleep
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      test_cold();
      test_codes();
      test_sleep();
      give_verdict();
   end
   initial begin
      #200000;
      errors++;
      give_verdict();
   end
endmodule : tb_top
